/* File: verilog/fbc_pkg.sv */
// package: constants of the fieldbus converter setup block
package fbc_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFF_AXIS_CFG = 8'h00;
   localparam logic [7:0] OFF_AXIS_ACT = 8'h04;
   localparam logic [7:0] OFF_SWITCHES = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFF_CONTROL = 8'h18;
   // reset values
   localparam logic [15:0] AXIS_CFG_RST = 16'h0001;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   // link rate switch codes
   localparam logic [3:0] RATE_625K = 4'h7;
   localparam logic [3:0] RATE_BAD_MIN = 4'h8;
   // status / interrupt bit positions
   localparam int BIT_SW_ALARM = 0;
   localparam int BIT_FB_ERR = 1;
   localparam int BIT_SER_ERR = 2;
   localparam int BIT_UNCONF = 3;
   // control bit positions
   localparam int CTL_CONFIGURED = 0;
   // timing: 625 kbps link bit at 20 MHz, blink half period
   localparam int CLK_HZ = 20000000;
   localparam int LINK_BPS = 625000;
   localparam int LINK_BIT_CYC = CLK_HZ / LINK_BPS;
   localparam int BLINK_MS = 250;
   localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
endpackage

/* File: verilog/fbc_blinker.sv */
// blink generator for the fieldbus error indicator
`timescale 1ns/1ps
module fbc_blinker
   import fbc_pkg::*;
#(
   parameter int HalfCyc = BLINK_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control and output
   input wire logic enable,
   output logic blinkOut
);
   logic [23:0] cnt_q;
   logic [23:0] cnt_d;
   logic phase_q;
   logic wrap;

   // counter wraps every half period while enabled
   assign wrap = (cnt_q == 24'(HalfCyc - 1));
   assign cnt_d = (!enable || wrap) ? 24'h000000 : cnt_q + 24'h000001;
   assign blinkOut = enable & phase_q;

   // phase toggles at each wrap, restarts lit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 24'h000000;
         phase_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         if (!enable) begin
            phase_q <= 1'b1;
         end else if (wrap) begin
            phase_q <= ~phase_q;
         end
      end
   end
endmodule

/* File: verilog/fbc_setup.sv */
// top of the fieldbus converter setup: apb registers, switches, indicators
// Function
// R1: sixteen per-axis link enables are held, axis 0 enabled and axes 1 to 15 disabled by default.
// R2: changed link enables take effect only after the next power-up capture; reset reloads AXIS_CFG_RST before the capture, so edits never take effect.
// R3: a rate switch value of 7 runs the driver link at 625 kbps, and 7 is the factory value.
// R4: a rate switch value of 8 or higher at power-up raises the switch setting alarm.
// R5: rate switch values 0 to 6 are unusable but raise no alarm.
// R6: the node address comes from a tens and a units decimal switch, factory address 1.
// R7: powering up unconfigured lights the alarm indicator.
// R8: a fieldbus communication error blinks the red fieldbus error indicator.
// R9: a driver-side communication failure lights the red serial error indicator.
// R10: each driver must run at 625,000 bps and use an address whose link enable is set.
// R11: only drivers whose captured link enable is set are served; the rest are ignored.
`timescale 1ns/1ps
module fbc_setup
   import fbc_pkg::*;
#(
   parameter int BlinkCyc = BLINK_CYC,
   parameter int Axes = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // switches
   input wire logic [3:0] linkRateSwitch,
   input wire logic [3:0] nodeAddrTensSwitch,
   input wire logic [3:0] nodeAddrUnitsSwitch,
   // link-side events and requests
   input wire logic fieldbusCommErr,
   input wire logic serialCommErr,
   input wire logic [3:0] serialReqAxis,
   input wire logic serialReqValid,
   // link-side results
   output logic serialReqGrant,
   output logic [6:0] nodeAddress,
   output logic linkRunning,
   output logic [7:0] linkBitCycles,
   // indicators and interrupt
   output logic alarmIndicator,
   output logic fieldbusErrorIndicator,
   output logic serialErrorIndicator,
   output logic serialActivityIndicator,
   output logic irq
);
   // register state
   logic [15:0] axisCfg_q;
   logic [15:0] axisAct_q;
   logic [3:0] rate_q;
   logic swAlarm_q;
   logic configured_q;
   logic [3:0] irqStat_q;
   logic [3:0] irqStat_d;
   logic [3:0] irqMask_q;
   logic captured_q;
   logic serErr_q;
   logic [31:0] prdata_q;
   logic [6:0] nodeAddr_q;
   logic grant_q;

   // decoded bus strobes
   logic acc;
   logic wrEn;
   logic rdEn;
   logic mapped;
   logic selAxisCfg;
   logic selAxisAct;
   logic selSwitches;
   logic selStatus;
   logic selIrqStat;
   logic selIrqMask;
   logic selControl;
   logic [3:0] events;
   logic [3:0] statusLive;
   logic [31:0] rdMux;

   // two decimal digits to binary, clipping non-decimal digits to 9
   function automatic logic [6:0] decAddr(input logic [3:0] tens, input logic [3:0] units);
      logic [3:0] t;
      logic [3:0] u;
      t = (tens > 4'h9) ? 4'h9 : tens;
      u = (units > 4'h9) ? 4'h9 : units;
      // widen before the product so tens of 2 and above do not wrap in four bits
      return (7'(t) * 7'h0a) + 7'(u);
   endfunction

   // apb decode: zero wait states, unmapped offsets answer with an error
   assign acc = psel & penable;
   assign wrEn = acc & pwrite;
   assign rdEn = acc & ~pwrite;

   // one select per mapped offset
   assign selAxisCfg = (paddr == OFF_AXIS_CFG);
   assign selAxisAct = (paddr == OFF_AXIS_ACT);
   assign selSwitches = (paddr == OFF_SWITCHES);
   assign selStatus = (paddr == OFF_STATUS);
   assign selIrqStat = (paddr == OFF_IRQ_STAT);
   assign selIrqMask = (paddr == OFF_IRQ_MASK);
   assign selControl = (paddr == OFF_CONTROL);
   assign mapped = selAxisCfg | selAxisAct | selSwitches | selStatus |
                   selIrqStat | selIrqMask | selControl;

   // bus answer
   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata = prdata_q;

   // live status bits: switch alarm, fieldbus error, serial error, unconfigured
   assign statusLive = {~configured_q, serErr_q, fieldbusCommErr, swAlarm_q};

   // read data selection
   always_comb begin
      rdMux = 32'h00000000;
      unique case (paddr)
         OFF_AXIS_CFG: rdMux = {16'h0000, axisCfg_q};
         OFF_AXIS_ACT: rdMux = {16'h0000, axisAct_q};
         OFF_SWITCHES: rdMux = {17'h00000, nodeAddr_q, 4'h0, rate_q};
         OFF_STATUS: rdMux = {28'h0000000, statusLive};
         OFF_IRQ_STAT: rdMux = {28'h0000000, irqStat_q};
         OFF_IRQ_MASK: rdMux = {28'h0000000, irqMask_q};
         OFF_CONTROL: rdMux = {31'h00000000, configured_q};
         default: rdMux = 32'h00000000;
      endcase
   end

   // read data is registered at the setup cycle so it is stable in the access phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q <= 32'h00000000;
      end else if (psel && !penable) begin
         prdata_q <= rdMux;
      end
   end

   // stored link enables, written by software, survive until the next power-up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         axisCfg_q <= AXIS_CFG_RST; // [R1]
         irqMask_q <= IRQ_MASK_RST;
         configured_q <= 1'b0;
      end else if (wrEn) begin
         if (paddr == OFF_AXIS_CFG) begin
            axisCfg_q <= pwdata[15:0];
         end
         if (paddr == OFF_IRQ_MASK) begin
            irqMask_q <= pwdata[3:0];
         end
         if (paddr == OFF_CONTROL) begin
            configured_q <= pwdata[CTL_CONFIGURED];
         end
      end
   end

   // power-up capture, one clock after reset release; later edits are lost, as reset reloads the default before it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         captured_q <= 1'b0;
         axisAct_q <= 16'h0000;
         rate_q <= 4'h0;
         swAlarm_q <= 1'b0;
         nodeAddr_q <= 7'h00;
      end else if (!captured_q) begin
         captured_q <= 1'b1;
         axisAct_q <= axisCfg_q; // [R2]
         rate_q <= linkRateSwitch;
         swAlarm_q <= (linkRateSwitch >= RATE_BAD_MIN); // [R4] [R5]
         nodeAddr_q <= decAddr(nodeAddrTensSwitch, nodeAddrUnitsSwitch); // [R6]
      end
   end

   // link runs only at the supported rate code and only after capture
   assign linkRunning = captured_q & (rate_q == RATE_625K); // [R3]
   assign linkBitCycles = 8'(LINK_BIT_CYC); // [R3]
   assign nodeAddress = nodeAddr_q;

   // serve only enabled axes, registered grant
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         grant_q <= 1'b0;
      end else begin
         grant_q <= serialReqValid & linkRunning & axisAct_q[serialReqAxis]; // [R11]
      end
   end
   assign serialReqGrant = grant_q;

   // serial error latches until the next power-up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serErr_q <= 1'b0;
      end else if (serialCommErr) begin
         serErr_q <= 1'b1;
      end
   end

   // sticky events, cleared by reading the interrupt status register; a new event wins
   assign events = statusLive;
   assign irqStat_d = ((rdEn && paddr == OFF_IRQ_STAT) ? 4'h0 : irqStat_q) | events;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_q <= 4'h0;
      end else begin
         irqStat_q <= irqStat_d;
      end
   end
   assign irq = |(irqStat_q & irqMask_q);

   // indicators
   assign alarmIndicator = swAlarm_q | ~configured_q; // [R4] [R7]
   assign serialErrorIndicator = serErr_q; // [R9]
   assign serialActivityIndicator = grant_q;

   // fieldbus error indicator blinks while an error is present
   fbc_blinker #(
      .HalfCyc(BlinkCyc)
   ) u_blink (
      .clk(clk),
      .rst_n(rst_n),
      .enable(fieldbusCommErr), // [R8]
      .blinkOut(fieldbusErrorIndicator)
   );

   // checks
   chk_axis_reset: assert property (@(posedge clk) $rose(rst_n) |-> axisCfg_q == AXIS_CFG_RST)
      else $error("axis enables not at reset default"); // [R1]
   chk_enable_hold: assert property (@(posedge clk) disable iff (!rst_n)
      captured_q && $past(captured_q) |-> $stable(axisAct_q))
      else $error("active axis enables changed without power-up"); // [R2]
   chk_rate_run: assert property (@(posedge clk) disable iff (!rst_n)
      captured_q |-> linkRunning == (rate_q == 4'h7))
      else $error("link run state does not follow rate code"); // [R3]
   chk_rate_alarm: assert property (@(posedge clk) disable iff (!rst_n)
      captured_q |-> swAlarm_q == (rate_q >= 4'h8))
      else $error("switch alarm does not follow rate code"); // [R4]
   chk_low_noalarm: assert property (@(posedge clk) disable iff (!rst_n)
      captured_q && rate_q <= 4'h6 |-> !swAlarm_q)
      else $error("alarm raised for low rate code"); // [R5]
   chk_unconf_alarm: assert property (@(posedge clk) disable iff (!rst_n)
      !configured_q |-> alarmIndicator)
      else $error("alarm dark while unconfigured"); // [R7]
   chk_fb_blink: assert property (@(posedge clk) disable iff (!rst_n)
      !fieldbusCommErr |-> !fieldbusErrorIndicator)
      else $error("fieldbus error lit without error"); // [R8]
   chk_ser_err: assert property (@(posedge clk) disable iff (!rst_n)
      serialCommErr |=> serialErrorIndicator)
      else $error("serial error not lit"); // [R9]
   chk_grant_enabled: assert property (@(posedge clk) disable iff (!rst_n)
      serialReqValid && !axisAct_q[serialReqAxis] |=> !serialReqGrant)
      else $error("disabled axis served"); // [R11]

   // the bus never inserts wait states
   chk_ready_high: assert property (@(posedge clk) disable iff (!rst_n)
      pready)
      else $error("pready low");

   // unmapped offsets are refused in the access phase
   chk_err_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
      acc && !mapped |-> pslverr)
      else $error("unmapped access not refused");

   // mapped offsets never answer with an error
   chk_err_mapped: assert property (@(posedge clk) disable iff (!rst_n)
      acc && mapped |-> !pslverr)
      else $error("mapped access refused");

   // an unmasked cause raises the interrupt on the next edge
   chk_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
      (events & irqMask_q) != 4'h0 && !wrEn |=> irq)
      else $error("interrupt not raised");

   // a cleared mask keeps the interrupt low
   chk_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      irqMask_q == 4'h0 |-> !irq)
      else $error("interrupt raised while masked");

   // status bits stay set until the interrupt status register is read
   chk_stat_keep: assert property (@(posedge clk) disable iff (!rst_n)
      !(rdEn && selIrqStat) |=> (irqStat_q & $past(irqStat_q)) == $past(irqStat_q))
      else $error("sticky status lost without a read");

   // a read with no live cause clears the sticky status
   chk_stat_clear: assert property (@(posedge clk) disable iff (!rst_n)
      rdEn && selIrqStat && events == 4'h0 |=> irqStat_q == 4'h0)
      else $error("sticky status not cleared by read");

   // every live cause lands in the sticky status, also during a clearing read
   chk_stat_set: assert property (@(posedge clk) disable iff (!rst_n)
      events != 4'h0 |=> (irqStat_q & $past(events)) == $past(events))
      else $error("event not recorded");

   // mask write lands at the access edge
   chk_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
      wrEn && selIrqMask |=> irqMask_q == $past(pwdata[3:0]))
      else $error("mask write lost");

   // link enable write lands at the access edge
   chk_cfg_write: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
      wrEn && selAxisCfg |=> axisCfg_q == $past(pwdata[15:0]))
      else $error("link enable write lost");

   // capture happens once per power-up
   chk_capture_stay: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      captured_q |=> captured_q)
      else $error("capture repeated");

   // the capture copies the stored enables
   chk_capture_copy: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      !captured_q |=> axisAct_q == $past(axisCfg_q))
      else $error("capture did not copy enables");

   // node address stays within two decimal digits
   chk_node_range: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
      captured_q |-> nodeAddr_q <= 7'd99)
      else $error("node address out of range");

   // a bad rate code keeps the alarm lit
   chk_rate_lit: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      swAlarm_q |-> alarmIndicator)
      else $error("alarm dark with bad rate code");

   // no grant while the link is stopped
   chk_grant_link: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
      !linkRunning |=> !serialReqGrant)
      else $error("grant while link stopped");

   // an enabled axis on a running link is served
   chk_grant_served: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
      serialReqValid && linkRunning && axisAct_q[serialReqAxis] |=> serialReqGrant)
      else $error("enabled axis not served");

   // the fieldbus error indicator starts lit
   chk_fb_first: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      $rose(fieldbusCommErr) |-> fieldbusErrorIndicator)
      else $error("fieldbus error indicator not lit at error start");

   // the serial error indicator holds until reset
   chk_ser_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      serialErrorIndicator |=> serialErrorIndicator)
      else $error("serial error indicator dropped");
endmodule

/* File: test/fbc_drv_model.sv */
// behavioural model of the rs-485 motor drivers beyond the converter
`timescale 1ns/1ps
module fbc_drv_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bench commands
   input wire logic reqOn,
   input wire logic [3:0] reqAxis,
   input wire logic rateOk,
   // link side
   output logic serialReqValid,
   output logic [3:0] serialReqAxis,
   output logic serialCommErr
);
   // drivers run at the converter rate on an enabled address; a rate mismatch fails the link
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serialReqValid <= 1'b0;
         serialReqAxis <= 4'h0;
         serialCommErr <= 1'b0;
      end else begin
         serialReqValid <= reqOn;
         serialReqAxis <= reqOn ? reqAxis : ~serialReqAxis; // idle address flips to its complement each cycle
         serialCommErr <= !rateOk;
      end
   end
endmodule

/* File: test/fbc_setup_tb.sv */
// self-checking bench of the fieldbus converter setup block
`timescale 1ns/1ps
module fbc_setup_tb;
   import fbc_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, fbErr, reqOn, rateOk;
   logic serErr, reqValid, grant, linkRunning, alarm, fbInd, serInd, act, irq;
   logic [7:0] paddr, bitCyc;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] rate, tens, units, reqAxis, axis;
   logic [6:0] nodeAddr;
   logic [3:0] rates [4] = '{4'h6, 4'h7, 4'h8, 4'hf};
   int n_mismatch = 0;
   int comparisons = 0;

   // design with a short blink period, and the driver model
   fbc_setup #(.BlinkCyc(4)) u_fbc_setup (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .linkRateSwitch(rate), .nodeAddrTensSwitch(tens),
      .nodeAddrUnitsSwitch(units), .fieldbusCommErr(fbErr), .serialCommErr(serErr),
      .serialReqAxis(axis), .serialReqValid(reqValid), .serialReqGrant(grant),
      .nodeAddress(nodeAddr), .linkRunning(linkRunning), .linkBitCycles(bitCyc),
      .alarmIndicator(alarm), .fieldbusErrorIndicator(fbInd),
      .serialErrorIndicator(serInd), .serialActivityIndicator(act), .irq(irq));
   fbc_drv_model u_fbc_drv_model (.clk(clk), .rst_n(rst_n), .reqOn(reqOn),
      .reqAxis(reqAxis), .rateOk(rateOk), .serialReqValid(reqValid),
      .serialReqAxis(axis), .serialCommErr(serErr));

   // clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic report_and_stop();
      if (n_mismatch == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // read and compare, offsets above the map must be refused
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("prdata", e, q);
      chk("pslverr", {31'h0, a > 8'h18}, {31'h0, err});
   endtask

   // power cycle of the converter
   task automatic pwron();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   // one driver request, grant looked at in its single cycle
   task automatic req(input logic [3:0] a, input logic g);
      @(posedge clk);
      reqOn <= 1'b1;
      reqAxis <= a;
      @(posedge clk);
      reqOn <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("grant", {31'h0, g}, {31'h0, grant});
      chk("activity", {31'h0, g}, {31'h0, act});
   endtask

   // watchdog
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end

   // test sequence
   initial begin
      {rst_n, psel, penable, pwrite, fbErr, reqOn} = 6'h0;
      {paddr, pwdata, reqAxis, tens} = 48'h0;
      {rate, units, rateOk} = {4'h7, 4'h1, 1'b1};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(OFF_AXIS_CFG, 32'h1);
      rd(OFF_AXIS_ACT, 32'h1);
      rd(OFF_SWITCHES, 32'h107);
      chk("bitcycles", 32'd32, {24'h0, bitCyc});
      chk("alarm", 32'h1, {31'h0, alarm});
      rd(8'h1c, 32'h0);
      wr(OFF_AXIS_CFG, 32'h8001);
      rd(OFF_AXIS_CFG, 32'h8001);
      rd(OFF_AXIS_ACT, 32'h1);
      req(4'hf, 1'b0);
      req(4'h0, 1'b1);
      wr(OFF_IRQ_MASK, 32'h2);
      chk("irq", 32'h0, {31'h0, irq});
      fbErr <= 1'b1;
      repeat (2) @(negedge clk);
      chk("fberr", 32'h1, {31'h0, fbInd});
      repeat (4) @(negedge clk);
      chk("fberr", 32'h0, {31'h0, fbInd});
      chk("irq", 32'h1, {31'h0, irq});
      @(posedge clk);
      fbErr <= 1'b0;
      rd(OFF_IRQ_STAT, 32'ha);
      rd(OFF_IRQ_STAT, 32'h8);
      chk("irq", 32'h0, {31'h0, irq});
      rateOk <= 1'b0;
      repeat (3) @(negedge clk);
      chk("sererr", 32'h1, {31'h0, serInd});
      wr(OFF_CONTROL, 32'h1);
      rd(OFF_CONTROL, 32'h1);
      chk("alarm", 32'h0, {31'h0, alarm});
      rateOk <= 1'b1;
      foreach (rates[i]) begin
         rate <= rates[i];
         tens <= 4'h2;
         units <= 4'h5;
         pwron();
         rd(OFF_STATUS, {28'h0, 3'b100, rates[i] > 4'h7});
         rd(OFF_SWITCHES, {17'h0, 7'd25, 4'h0, rates[i]});
         chk("node", 32'd25, {25'h0, nodeAddr});
         chk("link", {31'h0, rates[i] == 4'h7}, {31'h0, linkRunning});
         req(4'h0, rates[i] == 4'h7);
      end
      report_and_stop();
   end
endmodule
